// file: src/addr_gen_regs.svh
`ifndef ADDR_GEN_REGS_SVH
`define ADDR_GEN_REGS_SVH

// Widths of the in-page offset, the page field and the immediate step
`define AG_ADDR_W      16
`define AG_PAGE_W      8
`define AG_IMM_W       8
// Page field position inside the 24-bit address
`define AG_PAGE_LSB    16
// Cursor registers per address unit
`define AG_UNIT_SLOTS  4
// Reset values
`define AG_CURSOR_RST  16'h0000
`define AG_STEP_RST    16'h0000
`define AG_SPAN_RST    16'h0000
`define AG_ORIGIN_RST  16'h0000
`define AG_PAGE_RST    8'h00
`define AG_REV_RST     1'b0

`endif

// file: src/addr_gen_pkg.sv
`default_nettype none

package addr_gen_pkg;

    // Target of an ordinary register load
    typedef enum logic [1:0] {
        LD_CURSOR,
        LD_STEP,
        LD_SPAN,
        LD_PAGE
    } load_kind_t;

    function automatic logic [15:0] bit_reverse(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < 16; k++) begin
            r[k] = v[15 - k];
        end
        return r;
    endfunction : bit_reverse

endpackage : addr_gen_pkg

`default_nettype wire

// file: src/addr_unit.sv
`include "addr_gen_regs.svh"
`default_nettype none

module addr_unit #(
    parameter bit REV_CAPABLE = 1'b0
) (
    input  wire logic [15:0] cursor,
    input  wire logic [15:0] step,
    input  wire logic [15:0] span,
    input  wire logic [15:0] origin,
    input  wire logic        post,
    input  wire logic        rev_en,
    output logic      [15:0] out_addr,
    output logic      [15:0] next_cursor
);

    // Unsigned in-page compare, widened so nothing overflows
    wire logic signed [17:0] sum      = $signed({2'b00, cursor}) + $signed({{2{step[15]}}, step});
    wire logic signed [17:0] lo       = $signed({2'b00, origin});
    wire logic signed [17:0] hi       = lo + $signed({2'b00, span});
    wire logic signed [17:0] span_x   = $signed({2'b00, span});
    wire logic               circ     = (span != 16'h0000);
    wire logic               wrap_up  = circ && !step[15] && (sum >= hi);
    wire logic               wrap_dn  = circ && step[15] && (sum < lo);
    wire logic signed [17:0] wrapped  = wrap_up ? sum - span_x :
                                        wrap_dn ? sum + span_x : sum;
    wire logic        [15:0] raw_addr = post ? cursor : sum[15:0];

    assign next_cursor = wrapped[15:0];
    assign out_addr    = (REV_CAPABLE && rev_en) ?
                         addr_gen_pkg::bit_reverse(raw_addr) : raw_addr;

endmodule : addr_unit

`default_nettype wire

// file: src/circular_bitrev_address_gen.sv
// What this block does
// - Base address of a circular buffer may hold any value.
// - Wrap-around happens only on post-modify accesses, never pre-modify.
// - Origin registers load only through the system register load path.
// - Post-modify drives the old cursor, then adds the step.
// - Sum inside the buffer is written back unchanged.
// - Overrun subtracts span, underrun adds span before writeback.
// - Modified cursor is compared with origin or origin plus span.
// - Step comes from a same-unit step register or an immediate.
// - Span is an unsigned length up to 65535.
// - Zero span means plain linear post-modify addressing.
// - Only the first unit reverses; the units work independently.
// - Reversal enable reverses every first-unit output address while set.
// - Only the output is reversed; writeback stays in normal order.
// - Full reversal maps output bit k to unreversed address bit 15 minus k.
// - Address is page in the upper eight bits, offset below.
// - Modify and wrap arithmetic never alter the page.
// - Pre-modify outputs cursor plus step without writeback.
// - Signed 8-bit immediate step is sign-extended before adding.
`include "addr_gen_regs.svh"
`default_nettype none

module circular_bitrev_address_gen #(
    parameter int SLOTS = `AG_UNIT_SLOTS
) (
    input  wire logic                     clock,
    input  wire logic                     srst,
    input  wire logic                     reversal_enable,
    input  wire logic                     load_valid,
    input  wire addr_gen_pkg::load_kind_t load_kind,
    input  wire logic                     load_unit,
    input  wire logic [1:0]               load_sel,
    input  wire logic [15:0]              load_data,
    input  wire logic                     sysreg_load_valid,
    input  wire logic                     sysreg_unit,
    input  wire logic [1:0]               sysreg_sel,
    input  wire logic [15:0]              sysreg_data,
    input  wire logic                     first_acc_valid,
    input  wire logic                     first_acc_post,
    input  wire logic [1:0]               first_acc_cursor,
    input  wire logic                     first_acc_use_imm,
    input  wire logic [1:0]               first_acc_step,
    input  wire logic [7:0]               first_acc_imm,
    input  wire logic                     second_acc_valid,
    input  wire logic                     second_acc_post,
    input  wire logic [1:0]               second_acc_cursor,
    input  wire logic                     second_acc_use_imm,
    input  wire logic [1:0]               second_acc_step,
    input  wire logic [7:0]               second_acc_imm,
    output logic      [23:0]              first_addr,
    output logic                          first_addr_valid,
    output logic      [23:0]              second_addr,
    output logic                          second_addr_valid,
    output logic                          rev_active
);

    localparam int ENTRIES = 2 * SLOTS;

    logic [15:0] cursor_ff [ENTRIES];
    logic [15:0] step_ff   [ENTRIES];
    logic [15:0] span_ff   [ENTRIES];
    logic [15:0] origin_ff [ENTRIES];
    logic [15:0] nxt_cursor[ENTRIES];
    logic [15:0] nxt_step  [ENTRIES];
    logic [15:0] nxt_span  [ENTRIES];
    logic [15:0] nxt_origin[ENTRIES];
    logic [7:0]  page_ff   [2];
    logic [7:0]  nxt_page  [2];
    logic [23:0] addr_ff   [2];
    logic        valid_ff  [2];
    logic        rev_ff;

    // Per-unit access request, packed for the generate loops
    wire logic       acc_valid [2];
    wire logic       acc_post  [2];
    wire logic [1:0] acc_cur   [2];
    wire logic       acc_imm_en[2];
    wire logic [1:0] acc_step  [2];
    wire logic [7:0] acc_imm   [2];
    assign acc_valid[0]  = first_acc_valid;
    assign acc_valid[1]  = second_acc_valid;
    assign acc_post[0]   = first_acc_post;
    assign acc_post[1]   = second_acc_post;
    assign acc_cur[0]    = first_acc_cursor;
    assign acc_cur[1]    = second_acc_cursor;
    assign acc_imm_en[0] = first_acc_use_imm;
    assign acc_imm_en[1] = second_acc_use_imm;
    assign acc_step[0]   = first_acc_step;
    assign acc_step[1]   = second_acc_step;
    assign acc_imm[0]    = first_acc_imm;
    assign acc_imm[1]    = second_acc_imm;

    wire logic [15:0] sel_cursor[2];
    wire logic [15:0] sel_step  [2];
    wire logic [15:0] sel_span  [2];
    wire logic [15:0] sel_origin[2];
    wire logic [15:0] unit_out  [2];
    wire logic [15:0] unit_next [2];

    for (genvar u = 0; u < 2; u++) begin : g_unit
        wire logic [2:0] cidx = {1'(u), acc_cur[u]};
        wire logic [2:0] sidx = {1'(u), acc_step[u]};
        assign sel_cursor[u] = cursor_ff[cidx];
        assign sel_span[u]   = span_ff[cidx];
        assign sel_origin[u] = origin_ff[cidx];
        assign sel_step[u]   = acc_imm_en[u] ? {{8{acc_imm[u][7]}}, acc_imm[u]}
                                             : step_ff[sidx];

        addr_unit #(
            .REV_CAPABLE (u == 0)
        ) u_unit (
            .cursor      (sel_cursor[u]),
            .step        (sel_step[u]),
            .span        (sel_span[u]),
            .origin      (sel_origin[u]),
            .post        (acc_post[u]),
            .rev_en      (reversal_enable),
            .out_addr    (unit_out[u]),
            .next_cursor (unit_next[u])
        );

        assign nxt_page[u] = (load_valid && load_kind == addr_gen_pkg::LD_PAGE &&
                              load_unit == 1'(u)) ? load_data[7:0] : page_ff[u];
    end

    // Register loads take priority over a writeback to the same cursor
    for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
        wire logic hit    = load_valid && ({load_unit, load_sel} == 3'(e));
        wire logic sys    = sysreg_load_valid && ({sysreg_unit, sysreg_sel} == 3'(e));
        wire logic wb     = acc_valid[e / SLOTS] && acc_post[e / SLOTS] &&
                            (acc_cur[e / SLOTS] == 2'(e % SLOTS));
        assign nxt_cursor[e] = (hit && load_kind == addr_gen_pkg::LD_CURSOR) ? load_data :
                               wb ? unit_next[e / SLOTS] : cursor_ff[e];
        assign nxt_step[e]   = (hit && load_kind == addr_gen_pkg::LD_STEP) ?
                               load_data : step_ff[e];
        assign nxt_span[e]   = (hit && load_kind == addr_gen_pkg::LD_SPAN) ?
                               load_data : span_ff[e];
        assign nxt_origin[e] = sys ? sysreg_data : origin_ff[e];
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < ENTRIES; i++) begin
            cursor_ff[i] <= srst ? `AG_CURSOR_RST : nxt_cursor[i];
            step_ff[i]   <= srst ? `AG_STEP_RST : nxt_step[i];
            span_ff[i]   <= srst ? `AG_SPAN_RST : nxt_span[i];
            origin_ff[i] <= srst ? `AG_ORIGIN_RST : nxt_origin[i];
        end
    end

    always_ff @(posedge clock) begin
        for (int u = 0; u < 2; u++) begin
            page_ff[u]  <= srst ? `AG_PAGE_RST : nxt_page[u];
            valid_ff[u] <= srst ? 1'b0 : acc_valid[u];
            if (srst) begin
                addr_ff[u] <= 24'h000000;
            end else if (acc_valid[u]) begin
                addr_ff[u] <= {page_ff[u], unit_out[u]};
            end
        end
        rev_ff <= srst ? `AG_REV_RST : reversal_enable;
    end

    assign first_addr        = addr_ff[0];
    assign first_addr_valid  = valid_ff[0];
    assign second_addr       = addr_ff[1];
    assign second_addr_valid = valid_ff[1];
    assign rev_active        = rev_ff;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Writeback index of each unit, for checks only
    wire logic [2:0] chk_idx0 = {1'b0, acc_cur[0]};
    wire logic [2:0] chk_idx1 = {1'b1, acc_cur[1]};
    wire logic       no_ld0   = !(load_valid && load_kind == addr_gen_pkg::LD_CURSOR &&
                                  {load_unit, load_sel} == chk_idx0);
    wire logic       no_ld1   = !(load_valid && load_kind == addr_gen_pkg::LD_CURSOR &&
                                  {load_unit, load_sel} == chk_idx1);

    post_old_addr_a: assert property (
        second_acc_valid && second_acc_post |=> second_addr[15:0] == $past(sel_cursor[1]))
        else $error("post-modify output is not the old cursor");

    pre_no_wb_a: assert property (
        second_acc_valid && !second_acc_post && no_ld1
        |=> cursor_ff[$past(chk_idx1)] == $past(sel_cursor[1]))
        else $error("pre-modify changed the cursor");

    pre_sum_a: assert property (
        second_acc_valid && !second_acc_post
        |=> second_addr[15:0] == 16'($past(sel_cursor[1]) + $past(sel_step[1])))
        else $error("pre-modify address is not cursor plus step");

    page_field_a: assert property (
        first_acc_valid |=> first_addr[23:16] == $past(page_ff[0]) && first_addr_valid)
        else $error("page field of address wrong");

    linear_step_a: assert property (
        second_acc_valid && second_acc_post && sel_span[1] == 16'h0000 && no_ld1
        |=> cursor_ff[$past(chk_idx1)] == 16'($past(sel_cursor[1]) + $past(sel_step[1])))
        else $error("zero span did not step linearly");

    rev_output_a: assert property (
        first_acc_valid && first_acc_post && reversal_enable
        |=> first_addr[15:0] == addr_gen_pkg::bit_reverse($past(sel_cursor[0])))
        else $error("first unit address not reversed");

    rev_wb_order_a: assert property (
        first_acc_valid && first_acc_post && reversal_enable && no_ld0
        |=> cursor_ff[$past(chk_idx0)] == $past(unit_next[0]) &&
            rev_active)
        else $error("reversed value written back");

    rev_wb_lin_a: assert property (
        first_acc_valid && first_acc_post && reversal_enable && no_ld0 &&
        sel_span[0] == 16'h0000
        |=> cursor_ff[$past(chk_idx0)] == 16'($past(sel_cursor[0]) + $past(sel_step[0])))
        else $error("reversed mode broke linear writeback");

    wrap_range_a: assert property (
        second_acc_valid && second_acc_post && no_ld1 && sel_span[1] != 16'h0000 &&
        {1'b0, sel_cursor[1]} >= {1'b0, sel_origin[1]} &&
        {1'b0, sel_cursor[1]} < {1'b0, sel_origin[1]} + {1'b0, sel_span[1]} &&
        {1'b0, sel_origin[1]} + {1'b0, sel_span[1]} <= 17'h10000 &&
        (sel_step[1][15] ? 16'(-sel_step[1]) : sel_step[1]) < sel_span[1]
        |=> {1'b0, cursor_ff[$past(chk_idx1)]} >= {1'b0, $past(sel_origin[1])} &&
            {1'b0, cursor_ff[$past(chk_idx1)]} <
            {1'b0, $past(sel_origin[1])} + {1'b0, $past(sel_span[1])})
        else $error("wrapped cursor left its buffer");

    origin_path_a: assert property (
        !sysreg_load_valid |=> origin_ff[0] == $past(origin_ff[0]))
        else $error("origin changed without system load");

endmodule : circular_bitrev_address_gen

`default_nettype wire

// file: tb/core_issue_model.sv
`default_nettype none

module core_issue_model (
    input  wire logic                clock,
    output logic                     reversal_enable = 1'b0,
    output logic                     load_valid = 1'b0,
    output addr_gen_pkg::load_kind_t load_kind = addr_gen_pkg::LD_CURSOR,
    output logic                     load_unit = 1'b0,
    output logic [1:0]               load_sel = 2'h0,
    output logic [15:0]              load_data = 16'h0000,
    output logic                     sysreg_load_valid = 1'b0,
    output logic                     sysreg_unit = 1'b0,
    output logic [1:0]               sysreg_sel = 2'h0,
    output logic [15:0]              sysreg_data = 16'h0000,
    output logic                     first_acc_valid = 1'b0,
    output logic                     first_acc_post = 1'b0,
    output logic [1:0]               first_acc_cursor = 2'h0,
    output logic                     first_acc_use_imm = 1'b0,
    output logic [1:0]               first_acc_step = 2'h0,
    output logic [7:0]               first_acc_imm = 8'h00,
    output logic                     second_acc_valid = 1'b0,
    output logic                     second_acc_post = 1'b0,
    output logic [1:0]               second_acc_cursor = 2'h0,
    output logic                     second_acc_use_imm = 1'b0,
    output logic [1:0]               second_acc_step = 2'h0,
    output logic [7:0]               second_acc_imm = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;

    // Load strobes stay up across back-to-back loads; idle drops them
    task automatic ld(input addr_gen_pkg::load_kind_t k, input logic u, input logic [1:0] s,
                      input logic [15:0] d);
        load_kind = k;
        {load_unit, load_sel, load_data} = {u, s, d};
        load_valid = 1'b1;
        sysreg_load_valid = 1'b0;
        @(posedge clock);
        #2;
    endtask : ld

    // Origin registers only through the system load path
    task automatic sys(input logic u, input logic [1:0] s, input logic [15:0] d);
        {sysreg_unit, sysreg_sel, sysreg_data} = {u, s, d};
        sysreg_load_valid = 1'b1;
        load_valid = 1'b0;
        @(posedge clock);
        #2;
    endtask : sys

    task automatic acc(input logic rev, input logic u, input logic p, input logic [1:0] c,
                       input logic i, input logic [1:0] s, input logic [7:0] m);
        reversal_enable = rev;
        {first_acc_post, first_acc_cursor, first_acc_use_imm, first_acc_step} = {p, c, i, s};
        {second_acc_post, second_acc_cursor, second_acc_use_imm, second_acc_step} = {p, c, i, s};
        first_acc_imm = m;
        second_acc_imm = m;
        first_acc_valid = ~u;
        second_acc_valid = u;
        @(posedge clock);
        #2;
    endtask : acc

    task automatic idle();
        load_valid = 1'b0;
        sysreg_load_valid = 1'b0;
        first_acc_valid = 1'b0;
        second_acc_valid = 1'b0;
        @(posedge clock);
        #2;
    endtask : idle
endmodule : core_issue_model

`default_nettype wire

// file: tb/circular_bitrev_address_gen_tb.sv
`default_nettype none

module circular_bitrev_address_gen_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic rev, u, post; logic [1:0] cur; logic use_imm; logic [1:0] stp; logic [7:0] imm;
        logic [23:0] exp;
    } row_t;
    typedef struct packed {logic sys; logic [1:0] k; logic u; logic [1:0] s; logic [15:0] d;} ld_t;

    // Kind 0 cursor, 1 step, 2 span, 3 page; page first, origin last
    localparam ld_t loads [0:17] = '{
        '{0, 3, 0, 0, 16'h0012}, '{0, 0, 0, 0, 16'h1000}, '{0, 1, 0, 0, 16'h0003},
        '{0, 2, 0, 0, 16'h0004}, '{1, 0, 0, 0, 16'h1000}, '{0, 0, 0, 1, 16'h2000},
        '{0, 1, 0, 1, 16'hfffe}, '{0, 0, 0, 2, 16'hffff}, '{0, 0, 0, 3, 16'h2000},
        '{0, 1, 0, 3, 16'h0100}, '{0, 3, 1, 0, 16'h0034}, '{0, 0, 1, 0, 16'h1000},
        '{0, 1, 1, 0, 16'h0003}, '{0, 2, 1, 0, 16'h0004}, '{1, 0, 1, 0, 16'h1000},
        '{0, 0, 1, 2, 16'h0005}, '{0, 2, 1, 2, 16'h0006}, '{1, 0, 1, 2, 16'h0004}};
    localparam row_t rows [0:18] = '{
        '{0, 0, 1, 0, 0, 0, 8'h00, 24'h121000}, '{0, 0, 1, 0, 0, 0, 8'h00, 24'h121003},
        '{0, 0, 1, 0, 0, 0, 8'h00, 24'h121002},
        '{0, 0, 0, 0, 1, 0, 8'h7f, 24'h121080},
        '{0, 0, 1, 0, 1, 0, 8'h01, 24'h121001}, '{0, 0, 0, 0, 0, 0, 8'h00, 24'h121005},
        '{0, 0, 1, 0, 0, 1, 8'h00, 24'h121002}, '{0, 0, 1, 0, 0, 1, 8'h00, 24'h121000},
        '{0, 0, 1, 1, 0, 1, 8'h00, 24'h122000}, '{0, 0, 1, 1, 0, 1, 8'h00, 24'h121ffe},
        '{0, 1, 1, 2, 1, 0, 8'hfd, 24'h340005}, '{0, 1, 1, 2, 1, 0, 8'hfd, 24'h340008},
        '{0, 1, 1, 0, 0, 0, 8'h00, 24'h341000}, '{0, 1, 1, 0, 0, 0, 8'h00, 24'h341003},
        '{1, 0, 1, 3, 0, 3, 8'h00, 24'h120004}, '{1, 0, 1, 3, 0, 3, 8'h00, 24'h120084},
        '{1, 0, 0, 3, 1, 0, 8'h00, 24'h120044}, '{1, 1, 0, 2, 1, 0, 8'h00, 24'h340005},
        '{0, 0, 0, 2, 1, 0, 8'h02, 24'h120001}};

    logic clock;
    logic srst;
    int   bad_count = 0;
    int   checks = 0;
    row_t r;
    wire logic reversal_enable, load_valid, load_unit, sysreg_load_valid, sysreg_unit;
    wire logic first_acc_valid, first_acc_post, first_acc_use_imm, second_acc_valid;
    wire logic second_acc_post, second_acc_use_imm, first_addr_valid, second_addr_valid;
    wire logic rev_active;
    wire logic [1:0] load_sel, sysreg_sel, first_acc_cursor, first_acc_step;
    wire logic [1:0] second_acc_cursor, second_acc_step;
    wire logic [15:0] load_data, sysreg_data;
    wire logic [7:0] first_acc_imm, second_acc_imm;
    wire logic [23:0] first_addr, second_addr;
    wire addr_gen_pkg::load_kind_t load_kind;

    core_issue_model i_core (.clock, .reversal_enable, .load_valid, .load_kind, .load_unit,
        .load_sel, .load_data, .sysreg_load_valid, .sysreg_unit, .sysreg_sel, .sysreg_data,
        .first_acc_valid, .first_acc_post, .first_acc_cursor, .first_acc_use_imm, .first_acc_step,
        .first_acc_imm, .second_acc_valid, .second_acc_post, .second_acc_cursor,
        .second_acc_use_imm, .second_acc_step, .second_acc_imm);
    circular_bitrev_address_gen i_dut (.clock, .srst, .reversal_enable, .load_valid, .load_kind,
        .load_unit, .load_sel, .load_data, .sysreg_load_valid, .sysreg_unit, .sysreg_sel,
        .sysreg_data, .first_acc_valid, .first_acc_post, .first_acc_cursor, .first_acc_use_imm,
        .first_acc_step, .first_acc_imm, .second_acc_valid, .second_acc_post, .second_acc_cursor,
        .second_acc_use_imm, .second_acc_step, .second_acc_imm, .first_addr, .first_addr_valid,
        .second_addr, .second_addr_valid, .rev_active);

    task automatic cmp24(input string name, input logic [23:0] exp, input logic [23:0] got);
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
        checks++;
    endtask : cmp24

    task automatic cmp1(input string name, input logic exp, input logic got);
        if (got !== exp) begin
            $display("Error %s expected %b seen %b", name, exp, got);
            bad_count++;
        end
        checks++;
    endtask : cmp1

    task automatic test_done();
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        srst = 1'b1;
        repeat (3) @(posedge clock);
        #2;
        srst = 1'b0;
        cmp24("first_addr", 24'h000000, first_addr);
        cmp1("first_addr_valid", 1'b0, first_addr_valid);
        foreach (loads[n]) begin
            if (loads[n].sys) begin
                i_core.sys(loads[n].u, loads[n].s, loads[n].d);
            end else begin
                i_core.ld(addr_gen_pkg::load_kind_t'(loads[n].k), loads[n].u, loads[n].s,
                          loads[n].d);
            end
        end
        i_core.idle();
        foreach (rows[n]) begin
            r = rows[n];
            i_core.acc(r.rev, r.u, r.post, r.cur, r.use_imm, r.stp, r.imm);
            cmp24("addr", r.exp, r.u ? second_addr : first_addr);
            cmp1("addr_valid", 1'b1, r.u ? second_addr_valid : first_addr_valid);
            cmp1("other_valid", 1'b0, r.u ? first_addr_valid : second_addr_valid);
            cmp1("rev_active", r.rev, rev_active);
        end
        i_core.idle();
        cmp1("first_addr_valid", 1'b0, first_addr_valid);
        cmp24("first_addr", 24'h120001, first_addr);
        // Load and writeback on the same cursor at one edge
        fork
            i_core.ld(addr_gen_pkg::LD_CURSOR, 1'b0, 2'h0, 16'h0100);
            i_core.acc(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 2'h0, 8'h00);
        join
        cmp24("first_addr", 24'h121002, first_addr);
        i_core.idle();
        i_core.acc(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 2'h0, 8'h00);
        cmp24("first_addr", 24'h120100, first_addr);
        i_core.idle();
        srst = 1'b1;
        i_core.idle();
        srst = 1'b0;
        cmp24("first_addr", 24'h000000, first_addr);
        i_core.acc(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 2'h0, 8'h05);
        cmp24("first_addr", 24'h000005, first_addr);
        test_done();
    end
endmodule : circular_bitrev_address_gen_tb

`default_nettype wire
